// [hdl/fsrm_top.sv]
`timescale 1ns/1ns
// Behaviour
// - While code runs from on-chip memory the program fetch strobe stays high.
// - While code runs from external memory the strobe pulses low twice per machine cycle.
// - Each external data access omits two consecutive program fetch strobe pulses.
// - Reset held high over ten machine cycles plus a forced strobe fall enters host mode.
// - Reset sampled high for two consecutive machine cycles resets the device.
// - Without a strobe fall during reset the device leaves reset in normal mode.
// - Data writes use an active-low write strobe and reads a separate read strobe.
module fsrm_top
    import fsrm_pkg::*;
(
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rstn,
    // Core control
    input  wire logic       double_speed,
    input  wire logic       exec_external,
    input  wire logic       data_req,
    input  wire logic       data_write,
    // Pins
    input  wire logic       reset_pin,
    input  wire logic       program_fetch_strobe_n_in,
    output logic            program_fetch_strobe_n_out,
    output logic            program_fetch_strobe_n_oe_n,
    output logic            data_wr_n,
    output logic            data_rd_n,
    // Status
    output logic            core_reset_q,
    output logic            host_mode_q,
    output logic            data_busy_q
);

    // ********************************************************************
    // Pin synchronisers and machine-cycle timing.
    // ********************************************************************
    logic [1:0] rst_sync_q;
    logic [1:0] strobe_sync_q;
    logic       strobe_prev_q;
    logic [3:0] phase;
    logic       mc_start;
    logic       half_start;

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rst_sync_q    <= 2'b00;
            strobe_sync_q <= 2'b11;
            strobe_prev_q <= 1'b1;
        end
        else
        begin
            rst_sync_q    <= {rst_sync_q[0], reset_pin};
            strobe_sync_q <= {strobe_sync_q[0], program_fetch_strobe_n_in};
            strobe_prev_q <= strobe_sync_q[1];
        end
    end

    fsrm_mc_timer u_timer
    (
        .ref_clk      (ref_clk),
        .rstn         (rstn),
        .double_speed (double_speed),
        .phase_q      (phase),
        .mc_start_q   (mc_start),
        .half_start_q (half_start)
    );

    // ********************************************************************
    // Reset qualification and mode selection.
    // ********************************************************************
    logic [4:0] hold_mc_q;
    logic       fall_seen_q;
    fsrm_mode_t mode_q;
    logic       strobe_fall;

    // The strobe pin is an input while reset holds and in host mode, so a fall during reset is the host's.
    assign strobe_fall = strobe_prev_q && !strobe_sync_q[1] && core_reset_q;

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            hold_mc_q <= 5'h0;
        end
        else if (!rst_sync_q[1])
        begin
            hold_mc_q <= 5'h0;
        end
        else if (mc_start && hold_mc_q != 5'h1f)
        begin
            hold_mc_q <= hold_mc_q + 5'h1;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            core_reset_q <= 1'b1;
        end
        else if (!rst_sync_q[1])
        begin
            core_reset_q <= 1'b0;
        end
        else if (mc_start && hold_mc_q >= 5'(RESET_SAMPLE_MC - 1))
        begin
            core_reset_q <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            fall_seen_q <= 1'b0;
        end
        else if (!rst_sync_q[1])
        begin
            fall_seen_q <= 1'b0;
        end
        else if (strobe_fall && hold_mc_q > 5'(HOST_HOLD_MC))
        begin
            fall_seen_q <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            mode_q <= FSRM_MODE_RESET;
        end
        else
        begin
            unique case (mode_q)
                FSRM_MODE_RESET:
                begin
                    if (!rst_sync_q[1])
                    begin
                        mode_q <= fall_seen_q ? FSRM_MODE_HOST : FSRM_MODE_NORMAL;
                    end
                end
                FSRM_MODE_NORMAL, FSRM_MODE_HOST:
                begin
                    if (core_reset_q)
                    begin
                        mode_q <= FSRM_MODE_RESET;
                    end
                end
                default:
                begin
                    mode_q <= FSRM_MODE_RESET;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            host_mode_q <= 1'b0;
        end
        else
        begin
            host_mode_q <= (mode_q == FSRM_MODE_HOST);
        end
    end

    // ********************************************************************
    // Strobe generation.
    // ********************************************************************
    // A data access occupies the next whole machine cycle, which removes both
    // fetch pulses of that cycle; requests are taken only at a cycle start.
    fsrm_acc_t  acc_q;
    fsrm_acc_t  acc_d;
    logic [3:0] low_len;
    logic       run;
    logic       fetch_pulse;

    assign run         = (mode_q == FSRM_MODE_NORMAL) && !core_reset_q;
    assign low_len     = double_speed ? 4'(STROBE_LOW_X2) : 4'(STROBE_LOW_STD);
    // The new access is known in phase 0 already, so the first fetch pulse of
    // the access cycle is dropped together with the second.
    assign acc_d       = !mc_start ? acc_q
                       : (run && data_req) ? (data_write ? FSRM_ACC_WRITE : FSRM_ACC_READ)
                       : FSRM_ACC_IDLE;
    assign fetch_pulse = (phase < low_len) ||
                         (phase >= (double_speed ? 4'(OSC_PER_MC_X2 / 2) : 4'(OSC_PER_MC_STD / 2))
                          && phase < low_len
                          + (double_speed ? 4'(OSC_PER_MC_X2 / 2) : 4'(OSC_PER_MC_STD / 2)));

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            acc_q <= FSRM_ACC_IDLE;
        end
        else
        begin
            acc_q <= acc_d;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            program_fetch_strobe_n_out  <= 1'b1;
            program_fetch_strobe_n_oe_n <= 1'b1;
            data_wr_n                   <= 1'b1;
            data_rd_n                   <= 1'b1;
            data_busy_q                 <= 1'b0;
        end
        else
        begin
            program_fetch_strobe_n_oe_n <= !run;
            program_fetch_strobe_n_out  <= !(run && exec_external
                                             && acc_d == FSRM_ACC_IDLE
                                             && fetch_pulse);
            data_wr_n   <= !(run && acc_d == FSRM_ACC_WRITE && phase != PHASE_W1);
            data_rd_n   <= !(run && acc_d == FSRM_ACC_READ && phase != PHASE_W1);
            data_busy_q <= (acc_q != FSRM_ACC_IDLE);
        end
    end

    // ********************************************************************
    // Checks.
    // ********************************************************************
    a_internal_high: assert property (@(posedge ref_clk) disable iff (!rstn)
        !exec_external ##1 !exec_external |-> program_fetch_strobe_n_out)
        else $error("fetch strobe low while executing internally");

    a_skip_access: assert property (@(posedge ref_clk) disable iff (!rstn)
        $past(acc_d) != FSRM_ACC_IDLE |-> program_fetch_strobe_n_out)
        else $error("fetch strobe pulsed during data access");

    a_rw_exclusive: assert property (@(posedge ref_clk) disable iff (!rstn)
        !(!data_wr_n && !data_rd_n))
        else $error("read and write strobes low together");

    a_host_needs_fall: assert property (@(posedge ref_clk) disable iff (!rstn)
        $rose(host_mode_q) |-> $past(fall_seen_q, 2))
        else $error("host mode without strobe fall");

    a_host_entry: assert property (@(posedge ref_clk) disable iff (!rstn)
        mode_q == FSRM_MODE_RESET && fall_seen_q && !rst_sync_q[1] |-> ##2 host_mode_q)
        else $error("host mode not entered");

    a_reset_two_mc: assert property (@(posedge ref_clk) disable iff (!rstn)
        $rose(core_reset_q) |-> hold_mc_q >= 5'(RESET_SAMPLE_MC - 1))
        else $error("reset taken before two machine cycles");

    a_pulse_count: assert property (@(posedge ref_clk) disable iff (!rstn)
        run && exec_external && acc_d == FSRM_ACC_IDLE && phase == 4'h0
        |-> ##1 !program_fetch_strobe_n_out)
        else $error("fetch pulse missing at cycle start");

    a_half_pulse: assert property (@(posedge ref_clk) disable iff (!rstn)
        run && exec_external && acc_d == FSRM_ACC_IDLE && half_start && $stable(double_speed)
        |-> ##1 !program_fetch_strobe_n_out)
        else $error("fetch pulse missing at half cycle");

    a_oe_follows: assert property (@(posedge ref_clk) disable iff (!rstn)
        core_reset_q |-> ##1 program_fetch_strobe_n_oe_n)
        else $error("fetch strobe driven during reset");

    c_host_entry: cover property (@(posedge ref_clk) disable iff (!rstn) $rose(host_mode_q));
    c_write: cover property (@(posedge ref_clk) disable iff (!rstn) $fell(data_wr_n));
    c_read: cover property (@(posedge ref_clk) disable iff (!rstn) $fell(data_rd_n));
    c_fetch: cover property (@(posedge ref_clk) disable iff (!rstn)
        $fell(program_fetch_strobe_n_out));

endmodule

// [hdl/fsrm_pkg.sv]
package fsrm_pkg;

    // ********************************************************************
    // Machine-cycle timing.
    // ********************************************************************
    localparam int OSC_PER_MC_STD      = 12;
    localparam int OSC_PER_MC_X2       = 6;
    localparam int RESET_SAMPLE_MC     = 2;
    localparam int HOST_HOLD_MC        = 10;
    // Strobe low phase within a half machine cycle, in oscillator periods.
    localparam int STROBE_LOW_STD      = 3;
    localparam int STROBE_LOW_X2       = 2;
    localparam logic [3:0] PHASE_W1    = 4'h0;

    // ********************************************************************
    // Access kinds and operating modes.
    // ********************************************************************
    typedef enum logic [2:0]
    {
        FSRM_ACC_IDLE  = 3'b001,
        FSRM_ACC_READ  = 3'b010,
        FSRM_ACC_WRITE = 3'b100
    } fsrm_acc_t;

    typedef enum logic [2:0]
    {
        FSRM_MODE_RESET  = 3'b001,
        FSRM_MODE_NORMAL = 3'b010,
        FSRM_MODE_HOST   = 3'b100
    } fsrm_mode_t;

endpackage

// [hdl/fsrm_mc_timer.sv]
`timescale 1ns/1ns
// Machine-cycle timer: one oscillator period per ref_clk cycle.
module fsrm_mc_timer
    import fsrm_pkg::*;
(
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rstn,
    // Control
    input  wire logic       double_speed,
    // Phase outputs
    output logic [3:0]      phase_q,
    output logic            mc_start_q,
    output logic            half_start_q
);

    logic [3:0] last_phase;
    logic [3:0] half_phase;

    // One machine cycle is twelve or six oscillator periods.
    assign last_phase = double_speed ? 4'(OSC_PER_MC_X2 - 1) : 4'(OSC_PER_MC_STD - 1);
    assign half_phase = double_speed ? 4'(OSC_PER_MC_X2 / 2) : 4'(OSC_PER_MC_STD / 2);

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            phase_q <= 4'h0;
        end
        else if (phase_q >= last_phase)
        begin
            phase_q <= 4'h0;
        end
        else
        begin
            phase_q <= phase_q + 4'h1;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            mc_start_q   <= 1'b0;
            half_start_q <= 1'b0;
        end
        else
        begin
            mc_start_q   <= (phase_q >= last_phase);
            half_start_q <= (phase_q >= last_phase) || (phase_q == half_phase - 4'h1);
        end
    end

    // ********************************************************************
    // Period check.
    // ********************************************************************
    // A speed switch stretches or cuts one cycle, so a span is judged only
    // when the setting held still from one start to the next.
    logic [3:0] gap_q;
    logic       ds_prev_q;
    logic       ds_moved_q;

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            gap_q      <= 4'h0;
            ds_prev_q  <= 1'b0;
            ds_moved_q <= 1'b1;
        end
        else
        begin
            ds_prev_q <= double_speed;
            if (mc_start_q)
            begin
                gap_q      <= 4'h1;
                ds_moved_q <= (double_speed != ds_prev_q);
            end
            else
            begin
                if (gap_q != 4'hf)
                begin
                    gap_q <= gap_q + 4'h1;
                end
                ds_moved_q <= ds_moved_q || (double_speed != ds_prev_q);
            end
        end
    end

    a_mc_period: assert property (@(posedge ref_clk) disable iff (!rstn)
        mc_start_q && !ds_moved_q && double_speed == ds_prev_q
        |-> gap_q == (double_speed ? 4'(OSC_PER_MC_X2) : 4'(OSC_PER_MC_STD)))
        else $error("machine cycle length wrong");

endmodule

// [verif/fsrm_host_model.sv]
`timescale 1ns/1ns
// ********************************************************************
// Host side of the fetch strobe pin.
// ********************************************************************
module fsrm_host_model
(
    // Pin from the device
    input  wire logic pin_out,
    input  wire logic pin_oe_n,
    // Scenario control
    input  wire logic force_low,
    // Resolved pin
    output logic      pin_level
);
    // The host holds the released pin high so that no stray fall selects host mode.
    assign pin_level = pin_oe_n ? !force_low : pin_out;
endmodule

// [verif/fsrm_top_tb_top.sv]
`timescale 1ns/1ns
module fsrm_top_tb_top;
    import fsrm_pkg::*;

    // ********************************************************************
    // Signals and counters.
    // ********************************************************************
    logic ref_clk;
    logic rstn;
    logic double_speed;
    logic exec_external;
    logic data_req;
    logic data_write;
    logic reset_pin;
    logic force_low;
    logic pin_level;
    logic pin_out;
    logic pin_oe_n;
    logic wr_n;
    logic rd_n;
    logic core_reset_q;
    logic host_mode_q;
    logic data_busy_q;
    logic pin_p;
    logic wr_p;
    logic rd_p;
    int   n_mismatch;
    int   total_checks;
    int   falls_fs;
    int   falls_wr;
    int   falls_rd;

    fsrm_top DUT (
        .ref_clk                     (ref_clk),
        .rstn                        (rstn),
        .double_speed                (double_speed),
        .exec_external               (exec_external),
        .data_req                    (data_req),
        .data_write                  (data_write),
        .reset_pin                   (reset_pin),
        .program_fetch_strobe_n_in   (pin_level),
        .program_fetch_strobe_n_out  (pin_out),
        .program_fetch_strobe_n_oe_n (pin_oe_n),
        .data_wr_n                   (wr_n),
        .data_rd_n                   (rd_n),
        .core_reset_q                (core_reset_q),
        .host_mode_q                 (host_mode_q),
        .data_busy_q                 (data_busy_q)
    );

    fsrm_host_model host (
        .pin_out   (pin_out),
        .pin_oe_n  (pin_oe_n),
        .force_low (force_low),
        .pin_level (pin_level)
    );

    initial
    begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    // Falls are counted on the resolved pin, as the memory sees them.
    // Sampling mid-cycle keeps the count clear of the edge that moves the outputs.
    always @(negedge ref_clk)
    begin
        if (pin_p === 1'b1 && pin_level === 1'b0) falls_fs++;
        if (wr_p === 1'b1 && wr_n === 1'b0) falls_wr++;
        if (rd_p === 1'b1 && rd_n === 1'b0) falls_rd++;
        pin_p = pin_level;
        wr_p  = wr_n;
        rd_p  = rd_n;
    end

    // ********************************************************************
    // Shared tasks.
    // ********************************************************************
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("Error %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic count_win(int n, output int fs, output int wr, output int rd);
        int a;
        int b;
        int c;
        a = falls_fs;
        b = falls_wr;
        c = falls_rd;
        repeat (n) @(posedge ref_clk);
        fs = falls_fs - a;
        wr = falls_wr - b;
        rd = falls_rd - c;
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ********************************************************************
    // Scenarios.
    // ********************************************************************
    task automatic normal_entry();
        reset_pin <= 1'b1;
        repeat (36) @(posedge ref_clk);
        check("pin reset", core_reset_q, 1'b1);
        reset_pin <= 1'b0;
        repeat (12) @(posedge ref_clk);
        check("reset left", core_reset_q, 1'b0);
        check("normal mode", host_mode_q, 1'b0);
        check("strobe driven", pin_oe_n, 1'b0);
    endtask

    task automatic fetch(logic ext, logic ds, int exp_falls);
        int fs;
        int wr;
        int rd;
        exec_external <= ext;
        double_speed  <= ds;
        repeat (24) @(posedge ref_clk);
        count_win(48, fs, wr, rd);
        check("fetch falls", fs, exp_falls);
        check("no data strobe", wr + rd, 0);
    endtask

    task automatic access(logic w);
        int fs;
        int wr;
        int rd;
        exec_external <= 1'b1;
        double_speed  <= 1'b0;
        data_write    <= w;
        repeat (24) @(posedge ref_clk);
        data_req <= 1'b1;
        fork
            count_win(48, fs, wr, rd);
            begin
                for (int i = 0; i < 14 && data_busy_q !== 1'b1; i++) @(posedge ref_clk);
                check("access taken", data_busy_q, 1'b1);
                data_req <= 1'b0;
            end
        join
        check("fetch falls with access", fs, 6);
        check("write strobes", wr, {31'h0, w});
        check("read strobes", rd, {31'h0, !w});
    endtask

    task automatic short_reset();
        reset_pin <= 1'b1;
        repeat (8) @(posedge ref_clk);
        reset_pin <= 1'b0;
        repeat (8) @(posedge ref_clk);
        check("short pulse ignored", core_reset_q, 1'b0);
    endtask

    task automatic host_entry();
        reset_pin <= 1'b1;
        repeat (168) @(posedge ref_clk);
        force_low <= 1'b1;
        repeat (8) @(posedge ref_clk);
        reset_pin <= 1'b0;
        repeat (12) @(posedge ref_clk);
        check("host mode", host_mode_q, 1'b1);
        check("pin released", pin_oe_n, 1'b1);
    endtask

    initial
    begin
        repeat (3000) @(posedge ref_clk);
        n_mismatch++;
        wrap_up();
    end

    initial
    begin
        rstn          = 1'b0;
        double_speed  = 1'b0;
        exec_external = 1'b0;
        data_req      = 1'b0;
        data_write    = 1'b0;
        reset_pin     = 1'b0;
        force_low     = 1'b0;
        repeat (3) @(posedge ref_clk);
        rstn <= 1'b1;
        normal_entry();
        fetch(1'b0, 1'b0, 0);
        check("pin idle high", pin_level, 1'b1);
        fetch(1'b1, 1'b0, 8);
        fetch(1'b1, 1'b1, 16);
        access(1'b1);
        access(1'b0);
        short_reset();
        host_entry();
        wrap_up();
    end
endmodule
